// ### include/pllcs_regs.vh
`ifndef PLLCS_REGS_VH
`define PLLCS_REGS_VH

// Register addresses on the serial configuration port.
`define PLLCS_ADDR_TEST_CTRL 7'h25
`define PLLCS_ADDR_CAL_TIMING 7'h28
`define PLLCS_ADDR_STATUS 7'h40
`define PLLCS_ADDR_INIT_DONE 7'h41
`define PLLCS_ADDR_CAL_PUMP 7'h45
`define PLLCS_ADDR_REV_ARRAY 7'h46
`define PLLCS_ADDR_COMPARATOR 7'h47

// Reset values of the writable registers.
`define PLLCS_CAL_TIMING_RST 8'h15
`define PLLCS_TEST_CTRL_RST 8'h40

// Field positions of the calibration timing register.
`define PLLCS_ARRAY_WAIT_MSB 7
`define PLLCS_ARRAY_WAIT_LSB 6
`define PLLCS_OSC_WAIT_MSB 5
`define PLLCS_OSC_WAIT_LSB 4
`define PLLCS_THRESH_MSB 3
`define PLLCS_THRESH_LSB 0

// Field positions of the test control register.
`define PLLCS_FCOMP_EN_BIT 7
`define PLLCS_DITHER_BIT 6

// Field positions of the main status register.
`define PLLCS_ST_CAL_DONE 7
`define PLLCS_ST_LOCK_NOW 5
`define PLLCS_ST_LOCK_QUAL 4
`define PLLCS_ST_LOCK_PIN 2
`define PLLCS_ST_DATA_CLOCK_PIN_PIN 1
`define PLLCS_ST_DIO_PIN 0

// Field positions of the init-done register.
`define PLLCS_ID_FILTER 5
`define PLLCS_ID_PRBS 3
`define PLLCS_ID_SYNTH 2
`define PLLCS_ID_CAL_LOCK 0

// Settle counts in clock cycles, array, DAC and pump calibrations.
`define PLLCS_AP_WAIT0 7'h01
`define PLLCS_AP_WAIT1 7'h02
`define PLLCS_AP_WAIT2 7'h06
`define PLLCS_AP_WAIT3 7'h32

// Settle counts in clock cycles, oscillator current calibration.
`define PLLCS_OC_WAIT0 7'h01
`define PLLCS_OC_WAIT1 7'h0c
`define PLLCS_OC_WAIT2 7'h3f
`define PLLCS_OC_WAIT3 7'h7f

// Serial frame: seven address bits, a write bit, eight data bits.
`define PLLCS_RW_BIT_IDX 5'h07
`define PLLCS_FIRST_DATA_IDX 5'h08
`define PLLCS_LAST_BIT_IDX 5'h0f
`define PLLCS_FRAME_END 5'h10

`endif

// ### verilog/pllcs_sequencer.v
`timescale 1ns/1ps
`include "pllcs_regs.vh"

module pllcs_sequencer (
    input wire clock,
    input wire rst,
    input wire start,
    input wire [1:0] array_pump_wait_sel,
    input wire [1:0] osc_current_wait_sel,
    input wire [3:0] cal_decision_threshold,
    input wire freq_comp,
    output reg busy,
    output reg [1:0] phase,
    output reg decide,
    output reg decision,
    output reg done
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SETTLE = 2'h1;
    localparam [1:0] ST_DECIDE = 2'h2;
    localparam [1:0] PH_OSC_CURRENT = 2'h3;

    reg [1:0] state;
    reg [6:0] wait_cnt;
    reg [3:0] dec_cnt;
    reg [6:0] settle_len;
    reg [3:0] limit;

    // Phases 0 to 2 use the first selector, phase 3 the second.
    always @* begin
        settle_len = `PLLCS_AP_WAIT0;
        if (phase == PH_OSC_CURRENT) begin
            case (osc_current_wait_sel)
                2'h0: settle_len = `PLLCS_OC_WAIT0;
                2'h1: settle_len = `PLLCS_OC_WAIT1;
                2'h2: settle_len = `PLLCS_OC_WAIT2;
                default: settle_len = `PLLCS_OC_WAIT3;
            endcase
        end else begin
            case (array_pump_wait_sel)
                2'h0: settle_len = `PLLCS_AP_WAIT0;
                2'h1: settle_len = `PLLCS_AP_WAIT1;
                2'h2: settle_len = `PLLCS_AP_WAIT2;
                default: settle_len = `PLLCS_AP_WAIT3;
            endcase
        end
        limit = (cal_decision_threshold == 4'h0) ? 4'h1 :
            cal_decision_threshold;
    end

    always @(posedge clock) begin
        if (rst) begin
            state <= ST_IDLE;
            phase <= 2'h0;
            wait_cnt <= 7'h00;
            dec_cnt <= 4'h0;
            busy <= 1'b0;
            decide <= 1'b0;
            decision <= 1'b0;
            done <= 1'b0;
        end else begin
            decide <= 1'b0;
            done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state <= ST_SETTLE;
                        phase <= 2'h0;
                        wait_cnt <= 7'h01;
                        busy <= 1'b1;
                    end
                end
                // [RULE_01] Settle wait select.
                // [RULE_02] Current settle wait.
                ST_SETTLE: begin
                    if (wait_cnt >= settle_len) begin
                        state <= ST_DECIDE;
                        dec_cnt <= 4'h1;
                    end else begin
                        wait_cnt <= wait_cnt + 7'h01;
                    end
                end
                // [RULE_03] Decision threshold count.
                ST_DECIDE: begin
                    if (dec_cnt >= limit) begin
                        decide <= 1'b1;
                        decision <= freq_comp;
                        wait_cnt <= 7'h01;
                        if (phase == PH_OSC_CURRENT) begin
                            state <= ST_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end else begin
                            state <= ST_SETTLE;
                            phase <= phase + 2'h1;
                        end
                    end else begin
                        dec_cnt <= dec_cnt + 4'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end
endmodule // pllcs_sequencer

// ### verilog/pllcs_bank.v
// Contract
// [RULE_01] Two-bit wait picks 1, 2, 6, 50 cycles.
// [RULE_02] Current wait picks 1, 12, 63, 127 cycles.
// [RULE_03] Low nibble is decision threshold, default five.
// [RULE_04] Done flag clears at start, sets at end.
// [RULE_05] Status bit five shows instantaneous lock.
// [RULE_06] Status bit four shows qualified lock.
// [RULE_07] Status bits two to zero mirror pins.
// [RULE_08] Init bits five, three: filter, PRBS done.
// [RULE_09] Init bits two, zero: synthesizer, calibration done.
// [RULE_10] Readback holds applied DAC and pump values.
// [RULE_11] Three-bit silicon revision in top bits.
// [RULE_12] Low five bits show applied array setting.
// [RULE_13] Top bit mirrors frequency comparator output.
// [RULE_14] Bit six shows current comparator result.
// [RULE_15] Low six bits show applied calibration current.
// [RULE_16] Status at 40h and init-done read only.
// [RULE_17] Comparator output passes only when enabled; the sequencer decision takes it ungated.
// [RULE_18] Writes to read-only registers are ignored.
`timescale 1ns/1ps
`include "pllcs_regs.vh"

module pllcs_bank #(
    // Arbitrary neutral revision value.
    parameter [2:0] SILICON_REVISION = 3'h5
) (
    input wire clock,
    input wire rst,
    input wire psel_n,
    input wire pclk,
    input wire pdi,
    output reg pdo,
    output reg pdo_oe,
    input wire lock_pin,
    input wire data_clock_pin,
    input wire data_inout_pin,
    input wire lock_now,
    input wire lock_qualified,
    input wire freq_comp_raw,
    input wire osc_cal_comp,
    input wire shaping_filter_init_done,
    input wire prbs_init_done,
    input wire synthesizer_init_done,
    input wire cal_lock_init_done,
    input wire [3:0] cal_dac_value,
    input wire [3:0] pump_current_value,
    input wire [4:0] osc_array_value,
    input wire [5:0] osc_cal_current,
    input wire cal_start,
    output reg cal_complete,
    output wire cal_busy,
    output wire [1:0] cal_phase,
    output wire cal_decide,
    output wire cal_decision,
    output reg freq_comp_enable,
    output reg dither_clock_enable
);
    localparam SYNC_W = 10;
    localparam [SYNC_W-1:0] SYNC_RST = 10'h001;
    localparam I_PSEL = 0;
    localparam I_PCLK = 1;
    localparam I_PDI = 2;
    localparam I_LOCK_PIN = 3;
    localparam I_DATA_CLOCK_PIN = 4;
    localparam I_DIO = 5;
    localparam I_LOCK_NOW = 6;
    localparam I_LOCK_QUAL = 7;
    localparam I_FCOMP = 8;
    localparam I_OSC_COMP = 9;

    wire [SYNC_W-1:0] async_in;
    reg [SYNC_W-1:0] sync_a;
    reg [SYNC_W-1:0] sync_b;
    reg pclk_prev;
    reg [7:0] cal_timing;
    reg [7:0] test_ctrl;
    reg [4:0] bit_idx;
    reg [6:0] addr_shift;
    reg [6:0] data_shift;
    reg wr_frame;
    reg rd_frame;
    reg [7:0] tx_shift;
    reg [7:0] rdata;
    reg [7:0] status_word;
    reg [7:0] init_word;
    reg [7:0] comp_word;
    wire sel_active;
    wire pclk_rise;
    wire pclk_fall;
    wire seq_done;
    wire freq_comp_gated;

    assign async_in[I_PSEL] = psel_n;
    assign async_in[I_PCLK] = pclk;
    assign async_in[I_PDI] = pdi;
    assign async_in[I_LOCK_PIN] = lock_pin;
    assign async_in[I_DATA_CLOCK_PIN] = data_clock_pin;
    assign async_in[I_DIO] = data_inout_pin;
    assign async_in[I_LOCK_NOW] = lock_now;
    assign async_in[I_LOCK_QUAL] = lock_qualified;
    assign async_in[I_FCOMP] = freq_comp_raw;
    assign async_in[I_OSC_COMP] = osc_cal_comp;

    // Two-flop synchronisers for every input from outside the domain.
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
            always @(posedge clock) begin
                if (rst) begin
                    sync_a[gi] <= SYNC_RST[gi];
                    sync_b[gi] <= SYNC_RST[gi];
                end else begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    always @(posedge clock) begin
        if (rst) begin
            pclk_prev <= 1'b0;
        end else begin
            pclk_prev <= sync_b[I_PCLK];
        end
    end

    assign sel_active = ~sync_b[I_PSEL];
    assign pclk_rise = sel_active & sync_b[I_PCLK] & ~pclk_prev;
    assign pclk_fall = sel_active & ~sync_b[I_PCLK] & pclk_prev;

    // [RULE_17] Comparator output gating.
    assign freq_comp_gated = sync_b[I_FCOMP] & test_ctrl[`PLLCS_FCOMP_EN_BIT];

    // Read data assembly for every mapped address.
    always @* begin
        status_word = 8'h00;
        // [RULE_04] Calibration finished flag.
        status_word[`PLLCS_ST_CAL_DONE] = cal_complete;
        // [RULE_05] Instantaneous lock bit.
        status_word[`PLLCS_ST_LOCK_NOW] = sync_b[I_LOCK_NOW];
        // [RULE_06] Qualified lock bit.
        status_word[`PLLCS_ST_LOCK_QUAL] = sync_b[I_LOCK_QUAL];
        // [RULE_07] Live pin levels.
        status_word[`PLLCS_ST_LOCK_PIN] = sync_b[I_LOCK_PIN];
        status_word[`PLLCS_ST_DATA_CLOCK_PIN_PIN] = sync_b[I_DATA_CLOCK_PIN];
        status_word[`PLLCS_ST_DIO_PIN] = sync_b[I_DIO];
        init_word = 8'h00;
        // [RULE_08] Filter and PRBS done.
        init_word[`PLLCS_ID_FILTER] = shaping_filter_init_done;
        init_word[`PLLCS_ID_PRBS] = prbs_init_done;
        // [RULE_09] Synthesizer and calibration done.
        init_word[`PLLCS_ID_SYNTH] = synthesizer_init_done;
        init_word[`PLLCS_ID_CAL_LOCK] = cal_lock_init_done;
        // [RULE_13] Comparator mirror bit.
        // [RULE_14] Current comparator bit.
        // [RULE_15] Applied calibration current.
        comp_word = {freq_comp_gated, sync_b[I_OSC_COMP], osc_cal_current};
        case (addr_shift)
            `PLLCS_ADDR_TEST_CTRL: rdata = test_ctrl;
            `PLLCS_ADDR_CAL_TIMING: rdata = cal_timing;
            // [RULE_16] Read-only status map.
            `PLLCS_ADDR_STATUS: rdata = status_word;
            `PLLCS_ADDR_INIT_DONE: rdata = init_word;
            // [RULE_10] DAC and pump readback.
            `PLLCS_ADDR_CAL_PUMP: rdata = {cal_dac_value, pump_current_value};
            // [RULE_11] Revision and array readback.
            // [RULE_12] Applied array setting.
            `PLLCS_ADDR_REV_ARRAY: rdata = {SILICON_REVISION, osc_array_value};
            `PLLCS_ADDR_COMPARATOR: rdata = comp_word;
            default: rdata = 8'h00;
        endcase
    end

    // Serial frame decode: address, write flag, then data.
    always @(posedge clock) begin
        if (rst) begin
            bit_idx <= 5'h00;
            addr_shift <= 7'h00;
            data_shift <= 7'h00;
            wr_frame <= 1'b0;
            rd_frame <= 1'b0;
            tx_shift <= 8'h00;
            pdo <= 1'b0;
            pdo_oe <= 1'b0;
        end else if (!sel_active) begin
            bit_idx <= 5'h00;
            wr_frame <= 1'b0;
            rd_frame <= 1'b0;
            pdo_oe <= 1'b0;
        end else if (pclk_rise) begin
            if (bit_idx < `PLLCS_RW_BIT_IDX) begin
                addr_shift <= {addr_shift[5:0], sync_b[I_PDI]};
            end else if (bit_idx == `PLLCS_RW_BIT_IDX) begin
                wr_frame <= sync_b[I_PDI];
                rd_frame <= ~sync_b[I_PDI];
                if (!sync_b[I_PDI]) begin
                    tx_shift <= rdata;
                    pdo <= rdata[7];
                    pdo_oe <= 1'b1;
                end
            end else if (bit_idx < `PLLCS_FRAME_END) begin
                data_shift <= {data_shift[5:0], sync_b[I_PDI]};
            end
            if (bit_idx < `PLLCS_FRAME_END) begin
                bit_idx <= bit_idx + 5'h01;
            end
        end else if (pclk_fall) begin
            if (rd_frame && bit_idx > `PLLCS_FIRST_DATA_IDX &&
                    bit_idx < `PLLCS_FRAME_END) begin
                tx_shift <= {tx_shift[6:0], 1'b0};
                pdo <= tx_shift[6];
            end
        end
    end

    // Register writes land on the last data bit of a write frame.
    always @(posedge clock) begin
        if (rst) begin
            cal_timing <= `PLLCS_CAL_TIMING_RST;
            test_ctrl <= `PLLCS_TEST_CTRL_RST;
        end else if (sel_active && pclk_rise && wr_frame &&
                bit_idx == `PLLCS_LAST_BIT_IDX) begin
            // [RULE_18] Only writable addresses decode.
            case (addr_shift)
                `PLLCS_ADDR_CAL_TIMING: begin
                    cal_timing <= {data_shift, sync_b[I_PDI]};
                end
                `PLLCS_ADDR_TEST_CTRL: begin
                    // Reserved bits of the test control register read zero.
                    test_ctrl <= {data_shift[6:5], 6'h00};
                end
                default: begin
                    cal_timing <= cal_timing;
                end
            endcase
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            freq_comp_enable <= 1'b0;
            dither_clock_enable <= 1'b1;
        end else begin
            freq_comp_enable <= test_ctrl[`PLLCS_FCOMP_EN_BIT];
            dither_clock_enable <= test_ctrl[`PLLCS_DITHER_BIT];
        end
    end

    // [RULE_04] Clear at start, set at end; end wins.
    always @(posedge clock) begin
        if (rst) begin
            cal_complete <= 1'b0;
        end else begin
            if (seq_done) begin
                cal_complete <= 1'b1;
            end else if (cal_start && !cal_busy) begin
                cal_complete <= 1'b0;
            end
        end
    end

    // [RULE_01] Settle wait sequencer.
    pllcs_sequencer u_seq (
        .clock(clock),
        .rst(rst),
        .start(cal_start),
        .array_pump_wait_sel(
            cal_timing[`PLLCS_ARRAY_WAIT_MSB:`PLLCS_ARRAY_WAIT_LSB]),
        .osc_current_wait_sel(
            cal_timing[`PLLCS_OSC_WAIT_MSB:`PLLCS_OSC_WAIT_LSB]),
        .cal_decision_threshold(
            cal_timing[`PLLCS_THRESH_MSB:`PLLCS_THRESH_LSB]),
        .freq_comp(sync_b[I_FCOMP]),
        .busy(cal_busy),
        .phase(cal_phase),
        .decide(cal_decide),
        .decision(cal_decision),
        .done(seq_done)
    );
endmodule // pllcs_bank

// ### test/pllcs_bank_asserts.sv
`timescale 1ns/1ps
module pllcs_bank_asserts (
    input wire clock,
    input wire rst,
    input wire cal_start,
    input wire cal_complete,
    input wire cal_busy,
    input wire [1:0] cal_phase,
    input wire cal_decide
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    busy_on_start_a: assert property (cal_start && !cal_busy
        |=> cal_busy)
        else $error("calibration start not taken");
    done_clear_a: assert property (cal_start && !cal_busy &&
        !$past(cal_busy) |=> !cal_complete)
        else $error("done flag not cleared at start");
    done_set_a: assert property ($fell(cal_busy)
        |-> ##[0:1] cal_complete)
        else $error("done flag not set at end");
    done_hold_a: assert property (cal_complete && !(cal_start && !cal_busy)
        |=> cal_complete)
        else $error("done flag dropped without start");
    phase_step_a: assert property (cal_busy && $past(cal_busy) &&
        cal_phase != $past(cal_phase)
        |-> cal_phase - $past(cal_phase) == 2'h1)
        else $error("calibration phase skipped");
    early_end_a: assert property ($fell(cal_busy)
        |-> $past(cal_phase) == 2'h3)
        else $error("calibration ended before last phase");
    busy_bound_a: assert property ($rose(cal_busy)
        |-> ##[1:1000] !cal_busy)
        else $error("calibration too long");
    decide_pulse_a: assert property (cal_decide |=> !cal_decide)
        else $error("decision pulse too long");
    decide_busy_a: assert property (cal_decide |-> $past(cal_busy))
        else $error("decision outside calibration");
endmodule // pllcs_bank_asserts

bind pllcs_bank pllcs_bank_asserts u_pllcs_bank_asserts (
    .clock(clock),
    .rst(rst),
    .cal_start(cal_start),
    .cal_complete(cal_complete),
    .cal_busy(cal_busy),
    .cal_phase(cal_phase),
    .cal_decide(cal_decide)
);

// ### test/pllcs_host.sv
`timescale 1ns/1ps
module pllcs_host (
    input wire clock,
    input wire pdo,
    input wire pdo_oe,
    output reg psel_n,
    output reg pclk,
    output reg pdi
);
    initial begin
        psel_n = 1'b1;
        pclk = 1'b0;
        pdi = 1'b0;
    end

    // One frame: address, direction bit, data; read bits taken before rises.
    task automatic frame(input [6:0] addr, input wr, input [7:0] wd,
                         output [7:0] rd);
        reg [15:0] word;
        integer i;
        begin
            word = {addr, wr, wd};
            rd = 8'h00;
            @(posedge clock);
            psel_n <= 1'b0;
            for (i = 15; i >= 0; i = i - 1) begin
                pdi <= word[i];
                repeat (6) @(posedge clock);
                if (i < 8)
                    rd[i] = pdo_oe ? pdo : 1'bx;
                pclk <= 1'b1;
                repeat (6) @(posedge clock);
                pclk <= 1'b0;
            end
            repeat (6) @(posedge clock);
            psel_n <= 1'b1;
            // Released line no longer shows the last bit.
            pdi <= ~word[0];
            repeat (6) @(posedge clock);
        end
    endtask
endmodule // pllcs_host

// ### test/pll_calibration_status_bank_bench.sv
`timescale 1ns/1ps
module pll_calibration_status_bank_bench;
    // Arbitrary neutral revision value.
    localparam [2:0] REV = 3'h2;
    reg clock, rst, cal_start, lock_pin, data_clock_pin, data_inout_pin;
    reg lock_now, lock_qualified, freq_comp_raw, osc_cal_comp;
    reg filt_d, prbs_d, synth_d, cal_d;
    reg [3:0] cal_dac_value, pump_current_value;
    reg [4:0] osc_array_value;
    reg [5:0] osc_cal_current;
    wire psel_n, pclk, pdi, pdo, pdo_oe, cal_complete, cal_busy, cal_decide;
    wire cal_decision, freq_comp_enable, dither_clock_enable;
    wire [1:0] cal_phase;
    integer mismatches, total_checks, seed, i, n, n0;
    reg [7:0] rd, m_timing, m_ctrl, t;
    reg m_done;

    pllcs_bank #(.SILICON_REVISION(REV)) u_pllcs_bank (.clock(clock),
        .rst(rst), .psel_n(psel_n), .pclk(pclk), .pdi(pdi), .pdo(pdo),
        .pdo_oe(pdo_oe), .lock_pin(lock_pin), .data_clock_pin(data_clock_pin),
        .data_inout_pin(data_inout_pin), .lock_now(lock_now),
        .lock_qualified(lock_qualified), .freq_comp_raw(freq_comp_raw),
        .osc_cal_comp(osc_cal_comp), .shaping_filter_init_done(filt_d),
        .prbs_init_done(prbs_d), .synthesizer_init_done(synth_d),
        .cal_lock_init_done(cal_d), .cal_dac_value(cal_dac_value),
        .pump_current_value(pump_current_value),
        .osc_array_value(osc_array_value), .osc_cal_current(osc_cal_current),
        .cal_start(cal_start), .cal_complete(cal_complete),
        .cal_busy(cal_busy), .cal_phase(cal_phase), .cal_decide(cal_decide),
        .cal_decision(cal_decision), .freq_comp_enable(freq_comp_enable),
        .dither_clock_enable(dither_clock_enable));
    pllcs_host u_pllcs_host (.clock(clock), .pdo(pdo), .pdo_oe(pdo_oe),
        .psel_n(psel_n), .pclk(pclk), .pdi(pdi));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            if (mismatches == 0 && total_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    function [7:0] exp_reg(input [6:0] a);
        case (a)
            7'h40: exp_reg = {m_done, 1'b0, lock_now, lock_qualified, 1'b0,
                              lock_pin, data_clock_pin, data_inout_pin};
            7'h41: exp_reg = {2'h0, filt_d, 1'b0, prbs_d, synth_d, 1'b0, cal_d};
            7'h45: exp_reg = {cal_dac_value, pump_current_value};
            7'h46: exp_reg = {REV, osc_array_value};
            7'h47: exp_reg = {m_ctrl[7] & freq_comp_raw, osc_cal_comp,
                              osc_cal_current};
            7'h28: exp_reg = m_timing;
            7'h25: exp_reg = m_ctrl;
            default: exp_reg = 8'h00;
        endcase
    endfunction

    // Model cycle count: three array/pump-wait phases, one current-wait phase, four decisions.
    function integer cal_len(input [7:0] v);
        integer a, c;
        begin
            case (v[7:6])
                2'h0: a = 1;
                2'h1: a = 2;
                2'h2: a = 6;
                default: a = 50;
            endcase
            case (v[5:4])
                2'h0: c = 1;
                2'h1: c = 12;
                2'h2: c = 63;
                default: c = 127;
            endcase
            cal_len = 3 * a + c + 4 * ((v[3:0] == 4'h0) ? 1 : v[3:0]);
        end
    endfunction

    task wr_reg(input [6:0] a, input [7:0] d);
        begin
            u_pllcs_host.frame(a, 1'b1, d, rd);
            if (a == 7'h28)
                m_timing = d;
            if (a == 7'h25)
                m_ctrl = d & 8'hc0;
        end
    endtask

    task rd_reg(input [6:0] a);
        begin
            u_pllcs_host.frame(a, 1'b0, 8'h00, rd);
            check(rd, exp_reg(a));
        end
    endtask

    // A write to a read-only address must leave its readback intact.
    task ro_pair(input [6:0] a);
        begin
            wr_reg(a, $random(seed));
            rd_reg(a);
        end
    endtask

    task shuffle;
        reg [31:0] r;
        begin
            r = $random(seed);
            @(posedge clock);
            {lock_pin, data_clock_pin, data_inout_pin, lock_now, lock_qualified,
             freq_comp_raw, osc_cal_comp, filt_d, prbs_d, synth_d, cal_d,
             cal_dac_value, pump_current_value, osc_array_value,
             osc_cal_current} <= r[29:0];
        end
    endtask

    // Runs one calibration with a refused second start, returns the cycles it stays busy after that start.
    task run_cal(input [7:0] v, output integer len);
        begin
            wr_reg(7'h28, v);
            @(posedge clock);
            cal_start <= 1'b1;
            @(posedge clock);
            cal_start <= 1'b0;
            m_done = 1'b0;
            repeat (3) @(posedge clock);
            cal_start <= 1'b1;
            @(posedge clock);
            cal_start <= 1'b0;
            len = 0;
            while (cal_busy === 1'b1 && len < 2000) begin
                @(posedge clock);
                len = len + 1;
            end
            if (len >= 2000)
                mismatches = mismatches + 1;
            repeat (2) @(posedge clock);
            m_done = 1'b1;
        end
    endtask

    initial begin
        mismatches = 0;
        total_checks = 0;
        seed = 83868;
        {rst, cal_start, lock_pin, data_clock_pin, data_inout_pin} = 5'h10;
        {lock_now, lock_qualified, freq_comp_raw, osc_cal_comp} = 4'h0;
        {filt_d, prbs_d, synth_d, cal_d} = 4'h0;
        {cal_dac_value, pump_current_value} = 8'h00;
        osc_array_value = 5'h00;
        osc_cal_current = 6'h00;
        m_timing = 8'h15;
        m_ctrl = 8'h40;
        m_done = 1'b0;
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        rd_reg(7'h28);
        rd_reg(7'h25);
        check(dither_clock_enable, 1);
        for (i = 0; i < 4; i = i + 1) begin
            wr_reg(7'h25, i[0] ? 8'hff : 8'h3f);
            check(freq_comp_enable, m_ctrl[7]);
            check(dither_clock_enable, m_ctrl[6]);
            rd_reg(7'h25);
            shuffle;
            ro_pair(7'h40);
            ro_pair(7'h41);
            ro_pair(7'h45);
            ro_pair(7'h46);
            ro_pair(7'h47);
            wr_reg(7'h10, 8'ha5);
            rd_reg(7'h10);
        end
        run_cal(8'h01, n0);
        for (i = 0; i < 16; i = i + 1) begin
            freq_comp_raw <= i[0];
            t = {i[3:0], 4'h0} | ($random(seed) & 8'h0f);
            run_cal(t, n);
            check(n - n0, cal_len(t) - cal_len(8'h01));
            check(cal_complete, 1);
            check(cal_decision, freq_comp_raw);
            rd_reg(7'h40);
            rd_reg(7'h28);
        end
        give_verdict;
    end
endmodule // pll_calibration_status_bank_bench
